//--- bench/abi_dev_model.sv
// Purpose: behavioural front-end device answering the init controller
// Assumes: device clock is mclk while dev_clk_run is high
// Notes:   seq_err is sticky; status lines toggle between frames
`timescale 1ns/1ns
`default_nettype none
module abi_dev_model
   import abi_pkg::*;
#(
   parameter int POR_MIN = POR_WAIT_TCLK
)
(
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       dev_clk_run,
   input  wire logic       dev_reset_n,
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_addr,
   input  wire logic [7:0] cmd_data,
   input  wire logic       slow,
   input  wire logic [7:0] pos_off,
   input  wire logic [7:0] neg_off,
   output logic            cmd_ready,
   output logic            stat_valid,
   output logic [7:0]      stat_pos,
   output logic [7:0]      stat_neg,
   output logic            seq_err,
   output logic            amp_off,
   output logic            ref_int,
   output logic            comp_on,
   output logic            ch4_bias_neg
);
   logic [7:0]  regs [0:31];
   logic [16:0] clk_n;
   logic [2:0]  low_n;
   logic [2:0]  wait_n;
   logic [2:0]  tick;
   logic        rst_done;
   logic        taken;

   assign amp_off      = !regs[ADDR_THIRD_CONFIG[4:0]][6];
   assign ref_int      = regs[ADDR_THIRD_CONFIG[4:0]][5];
   assign comp_on      = regs[ADDR_FOURTH_CONFIG[4:0]][1];
   assign ch4_bias_neg = regs[ADDR_CH_FOUR_SET[4:0]][2:0] == 3'b111;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 32; i++)
            regs[i] <= 8'h00;
         {clk_n, low_n, wait_n, tick, rst_done, taken, seq_err} <= '0;
         {cmd_ready, stat_valid, stat_pos, stat_neg} <= '0;
      end
      else
      begin
         cmd_ready  <= 1'b0;
         stat_valid <= 1'b0;
         // never leave a stale status on the lines between frames
         stat_pos   <= ~stat_pos;
         stat_neg   <= ~stat_neg;
         if (!cmd_valid)
            taken <= 1'b0;
         if (!dev_clk_run)
         begin
            {clk_n, low_n, wait_n, rst_done} <= '0;
            if (cmd_valid)
               seq_err <= 1'b1;
         end
         else
         begin
            if (clk_n != '1)
               clk_n <= clk_n + 17'h1;
            tick <= tick + 3'h1;
            if (!dev_reset_n)
            begin
               if (low_n != 3'h7)
                  low_n <= low_n + 3'h1;
               rst_done <= 1'b0;
               if (clk_n < POR_MIN)
                  seq_err <= 1'b1;
            end
            else if (low_n != 3'h0)
            begin
               if (low_n < 3'(RST_LOW_TCLK))
                  seq_err <= 1'b1;
               low_n    <= 3'h0;
               rst_done <= 1'b1;
            end
            if (cmd_valid && !taken && !cmd_ready)
            begin
               if (!rst_done)
                  seq_err <= 1'b1;
               wait_n <= wait_n + 3'h1;
               if (wait_n >= (slow ? 3'h3 : 3'h0))
               begin
                  cmd_ready <= 1'b1;
                  wait_n    <= 3'h0;
               end
            end
            if (cmd_valid && cmd_ready)
            begin
               regs[cmd_addr[4:0]] <= cmd_data;
               taken <= 1'b1;
            end
            if (rst_done && tick == 3'h7)
            begin
               stat_valid <= 1'b1;
               stat_pos   <= comp_on ? pos_off & regs[ADDR_ELEC_OFF_POS[4:0]] : 8'h00;
               stat_neg   <= comp_on ? neg_off & regs[ADDR_ELEC_OFF_NEG[4:0]] : 8'h00;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/afe_powerup_bias_init_bench.sv
// Purpose: self-checking bench for the power-up and bias init controller
// Assumes: device model answers writes promptly or slowly
// Notes:   por count shortened to 16 cycles
`timescale 1ns/1ns
`default_nettype none
module afe_powerup_bias_init_bench;
   import abi_pkg::*;
   localparam int POR = 16;
   logic        mclk, resetn, supply_ok, electrode_off_config_enable, bias_meas_enable, bias_powerdown;
   logic        dev_clk_run, dev_reset_n, cmd_valid, cmd_ready, stat_valid;
   logic        elec_off_change, init_done, slow, seq_err, amp_off, ref_int, comp_on;
   logic        ch4_bias_neg;
   logic [7:0]  cmd_addr, cmd_data, stat_pos, stat_neg, elec_off_pos, elec_off_neg;
   logic [7:0]  pos_off, neg_off;
   int          failures, n_compared, hi_n, lo_n, por_seen;
   logic [15:0] wr_log[$];
   logic [15:0] exp_q[$];
   // {electrode_off_config, meas, powerdown, slow, expected write count}
   logic [7:0]  rows [0:4] = '{8'h87, 8'hD9, 8'h65, 8'h33, 8'hE9};

   abi_init_ctrl #(.POR_CYCLES(POR)) i_abi_init_ctrl (.mclk(mclk), .resetn(resetn),
      .supply_ok(supply_ok), .electrode_off_config_enable(electrode_off_config_enable), .bias_meas_enable(bias_meas_enable),
      .bias_powerdown(bias_powerdown), .dev_clk_run(dev_clk_run), .dev_reset_n(dev_reset_n),
      .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .stat_valid(stat_valid), .stat_pos(stat_pos), .stat_neg(stat_neg),
      .elec_off_pos(elec_off_pos), .elec_off_neg(elec_off_neg),
      .elec_off_change(elec_off_change), .init_done(init_done));

   abi_dev_model #(.POR_MIN(POR)) i_abi_dev_model (.mclk(mclk), .resetn(resetn),
      .dev_clk_run(dev_clk_run), .dev_reset_n(dev_reset_n), .cmd_valid(cmd_valid),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .slow(slow), .pos_off(pos_off),
      .neg_off(neg_off), .cmd_ready(cmd_ready), .stat_valid(stat_valid),
      .stat_pos(stat_pos), .stat_neg(stat_neg), .seq_err(seq_err), .amp_off(amp_off),
      .ref_int(ref_int), .comp_on(comp_on), .ch4_bias_neg(ch4_bias_neg));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
         wr_log.push_back({cmd_addr, cmd_data});
      if (dev_clk_run !== 1'b1)
      begin
         hi_n = 0;
         lo_n = 0;
      end
      else if (dev_reset_n === 1'b1)
         hi_n++;
      else
      begin
         if (lo_n == 0)
            por_seen = hi_n;
         lo_n++;
      end
   end

   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bound(input int k, input int lim);
      if (k == lim)
      begin
         failures++;
         tally_and_finish();
      end
   endtask

   task automatic wait_done;
      int k;
      for (k = 0; k < 600 && init_done !== 1'b1; k++)
         @(negedge mclk);
      bound(k, 600);
   endtask

   task automatic wait_stat;
      int k;
      for (k = 0; k < 20 && stat_valid !== 1'b1; k++)
         @(negedge mclk);
      bound(k, 20);
      @(negedge mclk);
   endtask

   task automatic start_seq(input logic [7:0] r);
      @(negedge mclk);
      {electrode_off_config_enable, bias_meas_enable, bias_powerdown, slow} = r[7:4];
      resetn    = 1'b0;
      supply_ok = 1'b0;
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      repeat (5) @(negedge mclk);
      check({dev_clk_run, dev_reset_n, cmd_valid, init_done}, 4'h0);
      wr_log.delete();
      supply_ok = 1'b1;
   endtask

   task automatic check_log(input logic [7:0] r);
      exp_q.delete();
      if (r[7])
      begin
         exp_q.push_back({ADDR_ELEC_OFF_CFG, 8'h00});
         exp_q.push_back({ADDR_FOURTH_CONFIG, 8'h02});
         exp_q.push_back({ADDR_ELEC_OFF_POS, 8'hFF});
         exp_q.push_back({ADDR_ELEC_OFF_NEG, 8'hFF});
      end
      exp_q.push_back({ADDR_BIAS_POS_SEL, 8'h07});
      exp_q.push_back({ADDR_BIAS_NEG_SEL, 8'h07});
      exp_q.push_back({ADDR_THIRD_CONFIG, 1'b0, !r[5], 1'b1, r[6], 4'hC});
      if (r[6])
      begin
         exp_q.push_back({ADDR_CH_FOUR_SET, 8'h07});
         exp_q.push_back({ADDR_CH_FIVE_SET, 8'h02});
      end
      check(wr_log.size(), r[3:0]);
      foreach (exp_q[i])
         check(wr_log[i], exp_q[i]);
      check(por_seen, POR);
      check(lo_n, 2);
      check(seq_err, 1'b0);
      check({amp_off, ref_int, comp_on, ch4_bias_neg},
            {r[5], 1'b1, r[7], r[6]});
   endtask

   initial
   begin
      int k;
      {resetn, supply_ok, electrode_off_config_enable, bias_meas_enable, bias_powerdown, slow} = '0;
      failures   = 0;
      n_compared = 0;
      for (int j = 0; j < 5; j++)
      begin
         pos_off = rows[j];
         neg_off = ~rows[j];
         start_seq(rows[j]);
         wait_done();
         check_log(rows[j]);
         wait_stat();
         check({elec_off_pos, elec_off_neg}, rows[j][7] ? {rows[j], ~rows[j]} : 16'h0);
      end
      // status change gives a single pulse, a repeat gives none
      pos_off = 8'h3C;
      wait_stat();
      check({elec_off_change, elec_off_pos}, 9'h13C);
      @(negedge mclk);
      check(elec_off_change, 1'b0);
      wait_stat();
      check(elec_off_change, 1'b0);
      // supply lost in mid-sequence, then a clean restart
      start_seq(8'hD9);
      for (k = 0; k < 200 && cmd_valid !== 1'b1; k++)
         @(negedge mclk);
      bound(k, 200);
      supply_ok = 1'b0;
      for (k = 0; k < 8 && {dev_clk_run, dev_reset_n, cmd_valid} !== 3'h0; k++)
         @(negedge mclk);
      bound(k, 8);
      check({dev_clk_run, dev_reset_n, cmd_valid, init_done}, 4'h0);
      wr_log.delete();
      supply_ok = 1'b1;
      wait_done();
      check_log(8'hD9);
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- rtl/abi_init_ctrl.sv
// Purpose: host-side power-up, reset and bias/electrode-off configuration sequencer
// Assumes: serial command engine on mclk accepts (cmd_addr, cmd_data) on cmd_valid & cmd_ready
// Notes:   device master clock is mclk gated by dev_clk_run; status input is same-domain
//
// Behaviour
// - all device inputs held low until supplies report stable (after a supply loss cmd_addr and cmd_data keep their last values)
// - device clock starts before the post-power-up wait is counted
// - wait 2^16 clock periods, then reset low for at least 2 periods
// - program configuration registers after reset release before claiming ready
// - in a chain only one device keeps bias amplifier powered
// - write 00h to electrode-off config for dc detection
// - write 02h to fourth config register to enable comparators
// - write FFh to both electrode-off sense-select registers
// - electrode-off results arrive as status bits in the data stream
// - write 07h to both bias sense-select registers
// - third config x11x1100 powers bias amp with internal reference
// - third config x1111100 additionally enables bias measurement
// - channel four low nibble 0111 routes bias return to negative input
// - channel five low nibble 0010 measures bias against reference
`timescale 1ns/1ns
`default_nettype none
module abi_init_ctrl
   import abi_pkg::*;
#(
   parameter int POR_CYCLES = POR_WAIT_CYC
)
(
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       supply_ok,
   input  wire logic       electrode_off_config_enable,
   input  wire logic       bias_meas_enable,
   input  wire logic       bias_powerdown,
   output logic            dev_clk_run,
   output logic            dev_reset_n,
   output logic            cmd_valid,
   output logic [7:0]      cmd_addr,
   output logic [7:0]      cmd_data,
   input  wire logic       cmd_ready,
   input  wire logic       stat_valid,
   input  wire logic [7:0] stat_pos,
   input  wire logic [7:0] stat_neg,
   output logic [7:0]      elec_off_pos,
   output logic [7:0]      elec_off_neg,
   output logic            elec_off_change,
   output logic            init_done
);

   localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYCLES - 1);
   localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_LOW_CYC - 1);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(SEQ_DEPTH - 1);

   typedef struct packed {
      abi_state_e       st;
      logic [CNT_W-1:0] cnt;
      logic [IDX_W-1:0] idx;
      logic             s1;
      logic             s2;
      logic             s3;
      logic             sup;
      logic             clk_run;
      logic             rst_n;
      logic             cmd_v;
      logic [7:0]       addr;
      logic [7:0]       data;
      logic [7:0]       lpos;
      logic [7:0]       lneg;
      logic             chg;
      logic             done;
   } abi_regs_s;

   abi_regs_s        r_r;
   abi_regs_s        r_nxt;
   logic [SEQ_W-1:0] rom_q;

   // ----------------------------------------------------------------
   // write table
   // ----------------------------------------------------------------
   abi_seq_rom #(
      .DEPTH (SEQ_DEPTH)
   ) u_rom (
      .mclk   (mclk),
      .resetn (resetn),
      .rd_idx (r_r.idx),
      .rd_q   (rom_q)
   );

   function automatic logic entry_skipped(input logic [1:0] cls,
                                          input logic       electrode_off_config_en,
                                          input logic       meas_en);
      entry_skipped = (cls == CLS_ELECTRODE_OFF_CONFIG && !electrode_off_config_en) || (cls == CLS_MEAS && !meas_en);
   endfunction

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      r_nxt     = r_r;
      r_nxt.chg = 1'b0;
      r_nxt.s1  = supply_ok;
      r_nxt.s2  = r_r.s1;
      r_nxt.s3  = r_r.s2;
      // a level change counts only once two stages agree
      if (r_r.s2 == r_r.s3)
         r_nxt.sup = r_r.s3;

      if (stat_valid)
      begin
         r_nxt.lpos = stat_pos;
         r_nxt.lneg = stat_neg;
         r_nxt.chg  = (stat_pos != r_r.lpos) || (stat_neg != r_r.lneg);
      end

      case (r_r.st)
         ABI_IDLE:
         begin
            r_nxt.cnt = '0;
            if (r_r.sup)
            begin
               r_nxt.clk_run = 1'b1;
               r_nxt.rst_n   = 1'b1;
               r_nxt.st      = ABI_CLKWAIT;
            end
         end
         ABI_CLKWAIT:
         begin
            r_nxt.cnt = r_r.cnt + 1'b1;
            if (r_r.cnt == POR_LAST)
            begin
               r_nxt.cnt   = '0;
               r_nxt.rst_n = 1'b0;
               r_nxt.st    = ABI_RSTLOW;
            end
         end
         ABI_RSTLOW:
         begin
            r_nxt.cnt = r_r.cnt + 1'b1;
            if (r_r.cnt == RST_LAST)
            begin
               r_nxt.rst_n = 1'b1;
               r_nxt.idx   = '0;
               r_nxt.st    = ABI_FETCH;
            end
         end
         ABI_FETCH:
            r_nxt.st = ABI_DECIDE;
         ABI_DECIDE:
         begin
            if (entry_skipped(rom_q[17:16], electrode_off_config_enable, bias_meas_enable))
            begin
               r_nxt.idx = r_r.idx + 1'b1;
               r_nxt.st  = (r_r.idx == IDX_LAST) ? ABI_DONE : ABI_FETCH;
            end
            else
            begin
               r_nxt.addr  = rom_q[15:8];
               r_nxt.data  = rom_q[7:0];
               // one amplifier per chain stays on, the rest take power-down
               if (rom_q[17:16] == CLS_CONF3)
                  r_nxt.data = {1'b0, !bias_powerdown, 1'b1, bias_meas_enable,
                                CONF3_LOW_NIBBLE};
               r_nxt.cmd_v = 1'b1;
               r_nxt.st    = ABI_SEND;
            end
         end
         ABI_SEND:
         begin
            if (cmd_ready)
            begin
               r_nxt.cmd_v = 1'b0;
               r_nxt.idx   = r_r.idx + 1'b1;
               r_nxt.st    = (r_r.idx == IDX_LAST) ? ABI_DONE : ABI_FETCH;
            end
         end
         ABI_DONE:
            r_nxt.done = 1'b1;
         default:
            r_nxt.st = ABI_IDLE;
      endcase

      // supplies lost: device clock, reset and cmd_valid go low again; cmd_addr and cmd_data keep their last values
      if (!r_r.sup)
      begin
         r_nxt.st      = ABI_IDLE;
         r_nxt.clk_run = 1'b0;
         r_nxt.rst_n   = 1'b0;
         r_nxt.cmd_v   = 1'b0;
         r_nxt.done    = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         r_r <= '{st: ABI_IDLE, default: '0};
      else
         r_r <= r_nxt;
   end

   assign dev_clk_run     = r_r.clk_run;
   assign dev_reset_n     = r_r.rst_n;
   assign cmd_valid       = r_r.cmd_v;
   assign cmd_addr        = r_r.addr;
   assign cmd_data        = r_r.data;
   assign elec_off_pos    = r_r.lpos;
   assign elec_off_neg    = r_r.lneg;
   assign elec_off_change = r_r.chg;
   assign init_done       = r_r.done;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [CNT_W:0] run_cnt_r;

   // counts cycles of running device clock, saturating
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         run_cnt_r <= '0;
      else if (!r_r.clk_run)
         run_cnt_r <= '0;
      else if (!run_cnt_r[CNT_W])
         run_cnt_r <= run_cnt_r + 1'b1;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_idle_pins_low;
      r_r.st == ABI_IDLE |-> !dev_clk_run && !dev_reset_n && !cmd_valid;
   endproperty
   a_idle_pins_low: assert property (p_idle_pins_low)
      else $error("device pins not low while idle");

   property p_clock_during_wait;
      r_r.st == ABI_CLKWAIT || r_r.st == ABI_RSTLOW |-> dev_clk_run;
   endproperty
   a_clock_during_wait: assert property (p_clock_during_wait)
      else $error("device clock stopped during power-up wait");

   property p_por_wait;
      // supply loss also drops reset early; only a planned pulse counts
      $fell(dev_reset_n) && $past(r_r.st) == ABI_CLKWAIT && r_r.sup
         |-> run_cnt_r >= (CNT_W+1)'(POR_CYCLES);
   endproperty
   a_por_wait: assert property (p_por_wait)
      else $error("reset issued before post-power-up wait elapsed");

   property p_reset_width;
      $fell(dev_reset_n) && r_r.sup |-> !dev_reset_n [*2];
   endproperty
   a_reset_width: assert property (p_reset_width)
      else $error("reset pulse shorter than two clocks");

   property p_no_write_in_reset;
      cmd_valid |-> dev_reset_n && dev_clk_run;
   endproperty
   a_no_write_in_reset: assert property (p_no_write_in_reset)
      else $error("write issued while device held in reset");

   property p_cmd_hold;
      cmd_valid && !cmd_ready && r_r.sup |=> cmd_valid && $stable(cmd_addr) && $stable(cmd_data);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold)
      else $error("write dropped or changed before acceptance");

   property p_electrode_off_config_value;
      cmd_valid && cmd_addr == ADDR_ELEC_OFF_CFG |-> cmd_data == VAL_ELEC_OFF_DC;
   endproperty
   a_electrode_off_config_value: assert property (p_electrode_off_config_value)
      else $error("electrode-off config not written for dc mode");

   property p_comp_enable;
      cmd_valid && cmd_addr == ADDR_FOURTH_CONFIG
         |-> cmd_data == VAL_COMP_ENABLE && cmd_data[COMP_EN_BIT];
   endproperty
   a_comp_enable: assert property (p_comp_enable)
      else $error("comparator enable write has wrong value");

   property p_conf3_value;
      // options are latched at decide, so compare against that cycle's inputs
      $rose(cmd_valid) && cmd_addr == ADDR_THIRD_CONFIG
         |-> cmd_data[3:0] == CONF3_LOW_NIBBLE && cmd_data[CONF3_REF_BIT]
             && cmd_data[CONF3_PWR_BIT] == !$past(bias_powerdown)
             && cmd_data[CONF3_MEAS_BIT] == $past(bias_meas_enable);
   endproperty
   a_conf3_value: assert property (p_conf3_value)
      else $error("third config value wrong");

   property p_ch4_route;
      cmd_valid && cmd_addr == ADDR_CH_FOUR_SET |-> cmd_data[2:0] == MUX_BIAS_TO_NEG;
   endproperty
   a_ch4_route: assert property (p_ch4_route)
      else $error("channel four not routed to bias return");

   property p_status_capture;
      stat_valid |=> elec_off_pos == $past(stat_pos) && elec_off_neg == $past(stat_neg);
   endproperty
   a_status_capture: assert property (p_status_capture)
      else $error("electrode-off status not captured");

endmodule
`default_nettype wire

//--- rtl/abi_pkg.sv
// Purpose: constants for the front-end power-up and bias/electrode-off init controller
// Assumes: device master clock is mclk itself, so one device clock period is one mclk cycle
// Notes:   register addresses other than the fourth config register are local choices
package abi_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int POR_WAIT_TCLK   = 65536;   // post_powerup_wait, device clock periods
   localparam int RST_LOW_TCLK    = 2;       // reset low width, device clock periods
   localparam int MCLK_PER_TCLK   = 1;       // device clock is mclk passed straight out
   localparam int POR_WAIT_CYC    = POR_WAIT_TCLK * MCLK_PER_TCLK;
   localparam int RST_LOW_CYC     = RST_LOW_TCLK * MCLK_PER_TCLK;
   localparam int CNT_W           = 17;

   // ----------------------------------------------------------------
   // device register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_THIRD_CONFIG   = 8'h03;
   localparam logic [7:0] ADDR_ELEC_OFF_CFG   = 8'h04;
   localparam logic [7:0] ADDR_CH_FOUR_SET    = 8'h08;
   localparam logic [7:0] ADDR_CH_FIVE_SET    = 8'h09;
   localparam logic [7:0] ADDR_BIAS_POS_SEL   = 8'h0D;
   localparam logic [7:0] ADDR_BIAS_NEG_SEL   = 8'h0E;
   localparam logic [7:0] ADDR_ELEC_OFF_POS   = 8'h0F;
   localparam logic [7:0] ADDR_ELEC_OFF_NEG   = 8'h10;
   localparam logic [7:0] ADDR_FOURTH_CONFIG  = 8'h17;

   // ----------------------------------------------------------------
   // register values
   // ----------------------------------------------------------------
   localparam logic [7:0] VAL_ELEC_OFF_DC     = 8'h00;
   localparam logic [7:0] VAL_COMP_ENABLE     = 8'h02;
   localparam logic [7:0] VAL_ALL_CHANNELS    = 8'hFF;
   localparam logic [7:0] VAL_CH_ONE_TO_THREE = 8'h07;
   localparam logic [7:0] VAL_CH4_BIAS_TO_NEG = 8'h07;
   localparam logic [7:0] VAL_CH5_BIAS_MEAS   = 8'h02;
   localparam logic [3:0] CONF3_LOW_NIBBLE    = 4'hC;
   localparam int         CONF3_MEAS_BIT      = 4;
   localparam int         CONF3_REF_BIT       = 5;
   localparam int         CONF3_PWR_BIT       = 6;
   localparam int         COMP_EN_BIT         = 1;
   localparam logic [2:0] MUX_BIAS_TO_POS     = 3'b110;
   localparam logic [2:0] MUX_BIAS_TO_NEG     = 3'b111;

   // ----------------------------------------------------------------
   // write sequence table: {class, addr, data}
   // ----------------------------------------------------------------
   localparam int         SEQ_W       = 18;
   localparam int         SEQ_DEPTH   = 9;
   localparam int         IDX_W       = 4;
   localparam logic [1:0] CLS_ALWAYS  = 2'h0;
   localparam logic [1:0] CLS_ELECTRODE_OFF_CONFIG    = 2'h1;
   localparam logic [1:0] CLS_MEAS    = 2'h2;
   localparam logic [1:0] CLS_CONF3   = 2'h3;

   typedef enum logic [2:0] {
      ABI_IDLE,
      ABI_CLKWAIT,
      ABI_RSTLOW,
      ABI_FETCH,
      ABI_DECIDE,
      ABI_SEND,
      ABI_DONE
   } abi_state_e;

endpackage

//--- rtl/abi_seq_rom.sv
// Purpose: table of configuration writes, registered read
// Assumes: one read per cycle, data valid the cycle after the address
// Notes:   entries past the table read as zero
`timescale 1ns/1ns
`default_nettype none
module abi_seq_rom
   import abi_pkg::*;
#(
   parameter int DEPTH = SEQ_DEPTH
)
(
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [SEQ_W-1:0] rd_q
);

   function automatic logic [SEQ_W-1:0] entry(input logic [IDX_W-1:0] i);
      case (i)
         4'h0:    entry = {CLS_ELECTRODE_OFF_CONFIG,   ADDR_ELEC_OFF_CFG,  VAL_ELEC_OFF_DC};
         4'h1:    entry = {CLS_ELECTRODE_OFF_CONFIG,   ADDR_FOURTH_CONFIG, VAL_COMP_ENABLE};
         4'h2:    entry = {CLS_ELECTRODE_OFF_CONFIG,   ADDR_ELEC_OFF_POS,  VAL_ALL_CHANNELS};
         4'h3:    entry = {CLS_ELECTRODE_OFF_CONFIG,   ADDR_ELEC_OFF_NEG,  VAL_ALL_CHANNELS};
         4'h4:    entry = {CLS_ALWAYS, ADDR_BIAS_POS_SEL,  VAL_CH_ONE_TO_THREE};
         4'h5:    entry = {CLS_ALWAYS, ADDR_BIAS_NEG_SEL,  VAL_CH_ONE_TO_THREE};
         4'h6:    entry = {CLS_CONF3,  ADDR_THIRD_CONFIG,  8'h00};
         4'h7:    entry = {CLS_MEAS,   ADDR_CH_FOUR_SET,   VAL_CH4_BIAS_TO_NEG};
         4'h8:    entry = {CLS_MEAS,   ADDR_CH_FIVE_SET,   VAL_CH5_BIAS_MEAS};
         default: entry = '0;
      endcase
   endfunction

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         rd_q <= '0;
      else
         rd_q <= (rd_idx < DEPTH) ? entry(rd_idx) : '0;
   end

endmodule
`default_nettype wire
